// ==== shared/deepc_pkg.sv ====
package deepc_pkg;
    localparam int DEEPC_AW = 7;
    localparam int DEEPC_COLW = 5;
    localparam int DEEPC_ROWW = DEEPC_AW - DEEPC_COLW;
    localparam int DEEPC_NLAT = 32;
    // Byte addresses on the Wishbone slave
    localparam logic [7:0] DEEPC_CSR_ADDR = 8'h30;
    localparam logic [7:0] DEEPC_OPT_ADDR = 8'h34;
    // Area select: adr_i[8] high reaches the array
    localparam int DEEPC_AREA_BIT = 8;
    localparam int DEEPC_LAT_BIT = 1;
    localparam int DEEPC_PGM_BIT = 0;
    localparam logic [7:0] DEEPC_CSR_RST = 8'h00;
    localparam logic [7:0] DEEPC_ERASED = 8'hFF;
    localparam int DEEPC_PROG_CYC = 1000;
    localparam int DEEPC_CNTW = 20;
    typedef enum logic [4:0] {
        DEEPC_IDLE  = 5'b0_0001,
        DEEPC_PROG  = 5'b0_0010,
        DEEPC_WAIT  = 5'b0_0100,
        DEEPC_HALT  = 5'b0_1000,
        DEEPC_ERASE = 5'b1_0000
    } deepc_state_e;
endpackage

// ==== shared/deepc_mem_if.sv ====
interface deepc_mem_if #(parameter int AW = 7);
    logic we;
    logic [AW-1:0] waddr;
    logic [7:0] wdata;
    logic [AW-1:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ==== hw/deepc_mem.sv ====
module deepc_mem
    import deepc_pkg::*;
#(
    parameter int AW = DEEPC_AW
) (
    // Clock
    input wire logic clk_i,
    // Port
    deepc_mem_if.mem m
);
    logic [7:0] cell_q [2**AW];
    logic [7:0] rdata_q;

    always_ff @(posedge clk_i) begin
        if (m.we) begin
            cell_q[m.waddr] <= m.wdata;
        end
        rdata_q <= cell_q[m.raddr];
    end
    assign m.rdata = rdata_q;
endmodule

// ==== hw/deepc_ctrl.sv ====
// Functional notes
// RL1: Read mode returns stored array bytes.
// RL2: Software sets latch bit, start bit clear.
// RL3: Write mode captures bytes into 32 latches.
// RL4: Start bit programs all captured latches.
// RL5: Row comes from last array write.
// RL6: Software keeps one row between programs.
// RL7: Cycle end clears start and latch together.
// RL8: Latches clear at end, latch-bit fall.
// RL9: Latched data is never readable.
// RL10: Wait request waits for running cycle.
// RL11: Halt request aborts programming at once.
// RL12: Array read in write mode undriven.
// RL13: Read-mode writes are not latched.
// RL14: Software must not abort a cycle.
// RL15: Protection blocks outside read and rewrite.
// RL16: Protection removal erases whole array.
// RL17: Control register resets zero, bits 7:2 zero.
// RL18: Latch bit software clear needs start clear.
// RL19: Start bit reads one while programming.
// RL20: Cycle length timed internally.
// RL21: Cycle length is a parameter.
// RL22: Row register loads on accepted writes.
//
// Added by the designer: register access over Wishbone.
module deepc_ctrl
    import deepc_pkg::*;
#(
    parameter int PROG_CYC = DEEPC_PROG_CYC
) (
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [0:0] sel_i,
    input wire logic [7:0] dat_i,
    output logic [7:0] dat_o,
    output logic ack_o,
    output logic dat_oe_o,
    // Power and option
    input wire logic wait_req_i,
    input wire logic halt_req_i,
    input wire logic protect_i,
    input wire logic ext_access_i,
    output logic wait_o,
    output logic erase_busy_o,
    output logic flash_erase_o
);
    localparam int ROWW = DEEPC_ROWW;
    localparam logic [DEEPC_CNTW-1:0] PROG_LAST = DEEPC_CNTW'(PROG_CYC - 1);
    localparam logic [DEEPC_CNTW-1:0] ERASE_LAST = DEEPC_CNTW'(2**DEEPC_AW - 1);

    deepc_mem_if #(.AW(DEEPC_AW)) mif ();
    deepc_mem #(.AW(DEEPC_AW)) u_mem (.clk_i(clk_i), .m(mif));

    function automatic logic is_area(input logic [15:0] a);
        return a[DEEPC_AREA_BIT];
    endfunction

    // Option input comes from pins, synchronise first
    logic prot_s1_q, prot_s2_q, prot_s3_q;
    logic ext_s1_q, ext_s2_q;
    always_ff @(posedge clk_i) begin
        prot_s1_q <= protect_i;
        prot_s2_q <= prot_s1_q;
        prot_s3_q <= prot_s2_q;
        ext_s1_q <= ext_access_i;
        ext_s2_q <= ext_s1_q;
    end
    logic prot_fall;
    assign prot_fall = prot_s3_q & ~prot_s2_q;

    deepc_state_e st_q, st_d;
    logic lat_q, lat_d, pgm_q, pgm_d;
    logic [7:0] latch_q [DEEPC_NLAT];
    logic [7:0] latch_d [DEEPC_NLAT];
    logic [DEEPC_NLAT-1:0] used_q, used_d;
    logic [ROWW-1:0] row_q, row_d;
    logic [DEEPC_CNTW-1:0] cnt_q, cnt_d;
    logic ack_q, ack_d, oe_q, oe_d;
    logic [7:0] dat_q, dat_d;
    logic rd_pend_q, rd_pend_d;

    logic req, wr, csr_hit, opt_hit, area_hit, blocked;
    assign req = cyc_i & stb_i & ~ack_q;
    assign wr = req & we_i & sel_i[0];
    assign csr_hit = adr_i[7:0] == DEEPC_CSR_ADDR && !is_area(adr_i);
    assign opt_hit = adr_i[7:0] == DEEPC_OPT_ADDR && !is_area(adr_i);
    assign area_hit = is_area(adr_i);
    // Outside access under protection sees nothing of the array, only the control and option registers
    assign blocked = prot_s2_q & ext_s2_q; // see RL15

    logic [7:0] csr_rd;
    assign csr_rd = {6'h00, lat_q, pgm_q}; // see RL17

    logic [DEEPC_COLW-1:0] prog_col;
    assign prog_col = cnt_q[DEEPC_COLW-1:0];

    always_comb begin
        st_d = st_q;
        lat_d = lat_q;
        pgm_d = pgm_q;
        latch_d = latch_q;
        used_d = used_q;
        row_d = row_q;
        cnt_d = cnt_q;
        ack_d = 1'b0;
        oe_d = 1'b0;
        dat_d = dat_q;
        rd_pend_d = 1'b0;
        mif.we = 1'b0;
        mif.waddr = {row_q, prog_col};
        mif.wdata = latch_q[prog_col] & mif.rdata;
        // Column 0 primed, so the first step of a cycle sees its old cell
        mif.raddr = {row_q, {DEEPC_COLW{1'b0}}};
        if (rd_pend_q) begin
            dat_d = mif.rdata; // see RL1
            oe_d = 1'b1;
            ack_d = 1'b1;
        end
        if (req && !rd_pend_q && st_q != DEEPC_HALT && st_q != DEEPC_ERASE) begin
            if (area_hit && !we_i) begin
                if (lat_q || blocked) begin
                    ack_d = 1'b1; // see RL12
                    oe_d = 1'b0; // see RL9
                end else if (st_q == DEEPC_IDLE) begin
                    mif.raddr = adr_i[DEEPC_AW-1:0];
                    rd_pend_d = 1'b1;
                end
            end else begin
                ack_d = 1'b1;
                oe_d = !we_i;
                dat_d = csr_hit ? csr_rd : (opt_hit ? {7'h00, prot_s2_q} : 8'h00);
            end
            if (wr && area_hit && lat_q && !pgm_q && !blocked) begin // see RL13
                latch_d[adr_i[DEEPC_COLW-1:0]] = latch_q[adr_i[DEEPC_COLW-1:0]] & dat_i; // see RL3
                used_d[adr_i[DEEPC_COLW-1:0]] = 1'b1;
                row_d = adr_i[DEEPC_AW-1:DEEPC_COLW]; // see RL5 RL22
            end
            // Write in read mode is dropped
            if (wr && csr_hit) begin
                if (dat_i[DEEPC_LAT_BIT]) begin
                    lat_d = 1'b1;
                end else if (!pgm_q) begin
                    lat_d = 1'b0; // see RL18
                end
                if (dat_i[DEEPC_PGM_BIT] && lat_q && !pgm_q && st_q == DEEPC_IDLE) begin
                    pgm_d = 1'b1; // see RL19
                    st_d = DEEPC_PROG;
                    cnt_d = '0;
                end else if (!dat_i[DEEPC_PGM_BIT] && pgm_q) begin
                    pgm_d = 1'b0; // see RL14
                    lat_d = dat_i[DEEPC_LAT_BIT];
                    st_d = DEEPC_IDLE;
                end
            end
        end
        unique case (st_q)
            DEEPC_IDLE: begin
                // A start taken in this cycle runs first, wait follows
                if (wait_req_i && !pgm_d) begin // see RL10
                    st_d = DEEPC_WAIT;
                end
            end
            DEEPC_PROG: begin
                mif.raddr = {row_q, DEEPC_COLW'(cnt_q + 1'b1)};
                if (cnt_q < DEEPC_CNTW'(DEEPC_NLAT)) begin
                    mif.we = used_q[prog_col]; // see RL4
                end
                cnt_d = cnt_q + 1'b1; // see RL20 RL21
                if (cnt_q == PROG_LAST) begin
                    pgm_d = 1'b0; // see RL7
                    lat_d = 1'b0;
                    st_d = wait_req_i ? DEEPC_WAIT : DEEPC_IDLE; // see RL10
                end
            end
            DEEPC_WAIT: begin
                if (!wait_req_i) begin
                    st_d = DEEPC_IDLE;
                end
            end
            DEEPC_HALT: begin
                if (!halt_req_i) begin
                    st_d = DEEPC_IDLE;
                end
            end
            DEEPC_ERASE: begin
                mif.we = 1'b1; // see RL16
                mif.waddr = cnt_q[DEEPC_AW-1:0];
                mif.wdata = DEEPC_ERASED;
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == ERASE_LAST) begin
                    st_d = DEEPC_IDLE;
                end
            end
        endcase
        if (halt_req_i && st_q != DEEPC_ERASE) begin
            st_d = DEEPC_HALT; // see RL11
            mif.we = 1'b0;
            pgm_d = 1'b0;
            lat_d = 1'b0;
        end
        if (prot_fall) begin
            st_d = DEEPC_ERASE;
            cnt_d = '0;
            pgm_d = 1'b0;
            lat_d = 1'b0;
        end
        // Latches cleared at cycle end or latch-bit fall
        if (lat_q && !lat_d) begin
            for (int i = 0; i < DEEPC_NLAT; i++) begin
                latch_d[i] = DEEPC_ERASED; // see RL8
            end
            used_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= DEEPC_IDLE;
            lat_q <= DEEPC_CSR_RST[DEEPC_LAT_BIT];
            pgm_q <= DEEPC_CSR_RST[DEEPC_PGM_BIT];
            for (int i = 0; i < DEEPC_NLAT; i++) begin
                latch_q[i] <= DEEPC_ERASED;
            end
            used_q <= '0;
            row_q <= '0;
            cnt_q <= '0;
            ack_q <= 1'b0;
            oe_q <= 1'b0;
            dat_q <= DEEPC_CSR_RST;
            rd_pend_q <= 1'b0;
        end else begin
            st_q <= st_d;
            lat_q <= lat_d;
            pgm_q <= pgm_d;
            latch_q <= latch_d;
            used_q <= used_d;
            row_q <= row_d;
            cnt_q <= cnt_d;
            ack_q <= ack_d;
            oe_q <= oe_d;
            dat_q <= dat_d;
            rd_pend_q <= rd_pend_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;
    assign dat_oe_o = oe_q;
    assign wait_o = st_q == DEEPC_WAIT || st_q == DEEPC_HALT;
    assign erase_busy_o = st_q == DEEPC_ERASE;
    assign flash_erase_o = st_q == DEEPC_ERASE;

    // Checker helpers: software abort strobe and start-bit run length
    localparam logic [DEEPC_CNTW-1:0] RUN_LEN = DEEPC_CNTW'(PROG_CYC);
    logic sw_abort;
    assign sw_abort = wr && csr_hit && !dat_i[DEEPC_PGM_BIT];
    logic [DEEPC_CNTW-1:0] run_q, run_d;
    always_comb begin
        run_d = pgm_q ? run_q + 1'b1 : '0;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_q <= '0;
        end else begin
            run_q <= run_d;
        end
    end

    end_clears_both_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RL7
        $fell(pgm_q) && !$past(halt_req_i) |-> !lat_q) else $error("start cleared without latch");
    csr_zero_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RL17
        req && csr_hit && !we_i && !rd_pend_q && st_q != DEEPC_HALT && st_q != DEEPC_ERASE
        |=> ack_q && dat_q[7:2] == 6'h00) else $error("reserved bits not zero");
    prog_length_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RL20 RL21
        $fell(pgm_q) && !$past(halt_req_i) && !$past(prot_fall) && !$past(sw_abort)
        |-> run_q == RUN_LEN) else $error("cycle length wrong");
    latch_read_float_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RL12
        req && area_hit && !we_i && lat_q && !rd_pend_q && st_q == DEEPC_IDLE |=> ack_q && !dat_oe_o)
        else $error("latched read drove bus");
    readmode_nolatch_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RL13
        !lat_q |=> used_q == '0 || $stable(used_q)) else $error("write latched in read mode");
    lat_clear_guard_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RL18
        $fell(lat_q) && $past(pgm_q) |-> !pgm_q) else $error("latch cleared while busy");
    halt_abort_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RL11
        halt_req_i && !erase_busy_o && !prot_fall |=> !pgm_q && wait_o) else $error("halt did not abort");
    latch_fall_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // see RL8
        $fell(lat_q) |-> used_q == '0) else $error("latches kept after fall");
endmodule

// ==== verif/deepc_core_model.sv ====
module deepc_core_model (
    // System
    input wire logic clk_i,
    // Wishbone master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [15:0] adr_o,
    output logic [0:0] sel_o,
    output logic [7:0] dat_o,
    input wire logic ack_i,
    input wire logic oe_i,
    input wire logic [7:0] dat_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cyc_o, stb_o, we_o, sel_o} = 4'h1;
        adr_o = 16'h0000;
        dat_o = 8'h00;
    end
    // Request held until ack, then released with scrambled lines
    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [8:0] r);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o} <= {2'b11, w};
        adr_o <= a;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        r = {oe_i, dat_i};
        {cyc_o, stb_o} <= 2'b00;
        adr_o <= ~a;
        dat_o <= ~d;
        @(posedge clk_i);
    endtask
endmodule

// ==== verif/tb_top.sv ====
module tb_top
    import deepc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PCYC = 40;
    localparam logic [15:0] CSR = {8'h00, DEEPC_CSR_ADDR};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wait_req_i = 1'b0;
    logic halt_req_i = 1'b0;
    logic protect_i = 1'b0;
    logic ext_access_i = 1'b0;
    logic cyc, stb, we, ack_o, dat_oe_o, wait_o, erase_busy_o, flash_erase_o;
    logic [15:0] adr;
    logic [0:0] sel;
    logic [7:0] wdat, dat_o;
    logic [9:0] exp_q[$];
    logic [7:0] mx[32];
    int n_fail = 0;
    int n_checks = 0;
    int cc = 0;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) cc <= cc + 1;
    deepc_ctrl #(.PROG_CYC(PCYC)) u_deepc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .dat_oe_o(dat_oe_o),
        .wait_req_i(wait_req_i), .halt_req_i(halt_req_i), .protect_i(protect_i), .ext_access_i(ext_access_i),
        .wait_o(wait_o), .erase_busy_o(erase_busy_o), .flash_erase_o(flash_erase_o));
    deepc_core_model u_deepc_core_model (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .ack_i(ack_o), .oe_i(dat_oe_o), .dat_i(dat_o));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [8:0] r;
        u_deepc_core_model.xfer(1'b1, a, d, r);
    endtask
    // Note bits: ignore, drive expected, data
    task automatic rd(input logic [15:0] a, input logic [9:0] e);
        logic [8:0] r;
        exp_q.push_back(e);
        u_deepc_core_model.xfer(1'b0, a, 8'h00, r);
    endtask
    task automatic poll(output int n);
        logic [8:0] r;
        int t0;
        t0 = cc;
        r = 9'h003;
        while (r[7:0] !== 8'h00 && cc - t0 < 2000) begin
            exp_q.push_back(10'h200);
            u_deepc_core_model.xfer(1'b0, CSR, 8'h00, r);
            cmp(16'(r[7:0] == 8'h03 || r[7:0] == 8'h00), 16'h0001);
        end
        n = cc - t0;
    endtask
    task automatic lvl(input logic v, input int lim, output int n);
        n = 0;
        while (((v ? wait_o : erase_busy_o) !== 1'b1) && n < lim) begin
            @(posedge clk_i);
            n++;
        end
    endtask
    always @(posedge clk_i) begin : mon
        logic [9:0] e;
        if (ack_o === 1'b1 && we === 1'b0) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h0ff;
            if (!e[9]) cmp({7'h00, dat_oe_o, e[8] ? dat_o : 8'h00}, {7'h00, e[8:0]});
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100_000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        int n, k, t;
        logic [7:0] d;
        n = $urandom(32'h6539_4a77);
        foreach (mx[i]) mx[i] = DEEPC_ERASED;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CSR, {2'b01, DEEPC_CSR_RST});
        wr(CSR, 8'hFC);
        rd(CSR, 10'h100);
        {protect_i, ext_access_i} <= 2'b11;
        repeat (8) @(posedge clk_i);
        rd(16'h0100, 10'h000);
        rd({8'h00, DEEPC_OPT_ADDR}, 10'h101);
        {protect_i, ext_access_i} <= 2'b00;
        lvl(1'b0, 50, n);
        cmp(16'(flash_erase_o), 16'h0001);
        n = 0;
        while (erase_busy_o !== 1'b0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        repeat (4) rd(16'h0100 | 16'($urandom_range(127)), {2'b01, DEEPC_ERASED});
        wr(16'h0105, 8'h00);
        rd(16'h0105, {2'b01, DEEPC_ERASED});
        wr(CSR, 8'h02);
        rd(CSR, 10'h102);
        rd(16'h0120, 10'h000);
        for (int i = 0; i < 8; i++) begin
            k = (i == 0 || i == 7) ? 0 : (i == 1) ? 31 : $urandom_range(31);
            d = 8'($urandom());
            wr(16'h0120 + 16'(k), d);
            mx[k] &= d;
        end
        // Whole span from the start write, so the start read is counted too
        t = cc;
        wr(CSR, 8'h03);
        rd(CSR, 10'h103);
        poll(n);
        cmp(16'(cc - t >= PCYC && cc - t < PCYC + 16), 16'h0001);
        for (int i = 0; i < 32; i++) rd(16'h0120 + 16'(i), {2'b01, mx[i]});
        wr(CSR, 8'h02);
        wr(16'h0120, 8'h0F);
        wr(CSR, 8'h00);
        rd(CSR, 10'h100);
        wr(CSR, 8'h02);
        d = 8'($urandom());
        wr(16'h0121, d);
        mx[1] &= d;
        wr(CSR, 8'h03);
        poll(n);
        rd(16'h0120, {2'b01, mx[0]});
        rd(16'h0121, {2'b01, mx[1]});
        wr(CSR, 8'h02);
        wr(16'h0160, 8'h5A);
        wr(CSR, 8'h03);
        wait_req_i <= 1'b1;
        lvl(1'b1, 300, n);
        cmp(16'(n > PCYC / 2 && n < 300), 16'h0001);
        wait_req_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        poll(n);
        rd(16'h0160, 10'h15A);
        wr(CSR, 8'h02);
        wr(16'h0140, 8'h00);
        wr(CSR, 8'h03);
        halt_req_i <= 1'b1;
        lvl(1'b1, 20, n);
        cmp(16'(n < 5), 16'h0001);
        halt_req_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rd(CSR, 10'h100);
        repeat (4) @(posedge clk_i);
        report_and_stop();
    end
endmodule
